// ---- bench/dpc_mem_model.sv ----
// Behavioural backing store and write sink on the device's core side.
`timescale 1ns/1ns
module dpc_mem_model (
   input wire logic clk,
   input wire logic stall,
   input wire logic rd_req,
   input wire logic [1:0] rd_bank,
   input wire logic [12:0] rd_row,
   input wire logic [9:0] rd_col,
   output logic [15:0] rd_data,
   input wire logic wq_valid,
   output logic wq_ready,
   input wire logic [42:0] wq_data
);
   logic [42:0] got[$];
   // Data is a pure function of the address; outside a request the bus
   // shows the inverse so stale data can never pass for a valid beat.
   always_comb begin
      if (rd_req) begin
         rd_data = {rd_bank, rd_col, rd_row[3:0]};
      end else begin
         rd_data = ~{rd_bank, rd_col, rd_row[3:0]};
      end
   end
   assign wq_ready = !stall;
   always @(posedge clk) begin
      if (wq_valid && wq_ready) begin
         got.push_back(wq_data);
      end
   end
endmodule : dpc_mem_model

// ---- bench/test_ddr2_pin_command_interface.sv ----
// Self-checking testbench for the DRAM pin command interface.
`timescale 1ns/1ns
module test_ddr2_pin_command_interface;
   localparam logic [3:0] LO = 4'h2;
   localparam logic [3:0] HI = 4'hC;
   logic clk = 1'b0, rst = 1'b1, cke = 1'b1, stall = 1'b0;
   logic cs_n = 1'b1, ras_n = 1'b1, cas_n = 1'b1, we_n = 1'b1;
   logic bank_sel_0 = 1'b0, bank_sel_1 = 1'b0, termination_ctl = 1'b0;
   logic low_byte_mask = 1'b0, high_byte_mask = 1'b0;
   logic stl = 1'b0, sth = 1'b0;
   logic [12:0] addr = 13'h0000;
   logic [15:0] dq_in = 16'h0000, dq_out, rd_data;
   logic dq_oe, strobe_oe, strobe_complement_oe, term_en, rd_req;
   logic low_byte_strobe_out, low_byte_strobe_complement_out;
   logic high_byte_strobe_out, high_byte_strobe_complement_out;
   logic wq_valid, wq_ready, wbuf_ready;
   logic [3:0] bank_open, pwr_state;
   logic [12:0] base_mode_reg, ext_mode_reg_1, ext_mode_reg_2;
   logic [12:0] ext_mode_reg_3, rd_row;
   logic [1:0] rd_bank;
   logic [9:0] rd_col;
   logic [42:0] wq_data;
   int n_fail = 0, cmp_count = 0, cycles = 0;

   dpc_top dut (.clk, .rst, .cke, .cs_n, .ras_n, .cas_n, .we_n,
      .bank_sel_0, .bank_sel_1, .addr, .low_byte_mask, .high_byte_mask,
      .termination_ctl, .dq_in, .low_byte_strobe_in(stl),
      .low_byte_strobe_complement_in(~stl), .high_byte_strobe_in(sth),
      .high_byte_strobe_complement_in(~sth), .dq_out, .dq_oe,
      .low_byte_strobe_out, .low_byte_strobe_complement_out,
      .high_byte_strobe_out, .high_byte_strobe_complement_out,
      .strobe_oe, .strobe_complement_oe, .term_en, .bank_open,
      .pwr_state, .base_mode_reg, .ext_mode_reg_1, .ext_mode_reg_2,
      .ext_mode_reg_3, .rd_req, .rd_bank, .rd_row, .rd_col, .rd_data,
      .wq_valid, .wq_ready, .wq_data, .wbuf_ready);
   dpc_mem_model mdl (.clk, .stall, .rd_req, .rd_bank, .rd_row, .rd_col,
      .rd_data, .wq_valid, .wq_ready, .wq_data);

   always #5 clk = ~clk;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task report_and_stop;
      $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk

   task cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= c;
      {bank_sel_1, bank_sel_0} <= b;
      addr <= a;
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= 4'hF;
   endtask : cmd

   task beat(input logic tl, th, ml, mh, input logic [15:0] d);
      dq_in <= d;
      low_byte_mask <= ml;
      high_byte_mask <= mh;
      if (tl) stl <= ~stl;
      if (th) sth <= ~sth;
      @(posedge clk);
   endtask : beat

   task wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_n

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      chk(pwr_state, 4'h1);
      chk(bank_open, 4'h0);
      chk({base_mode_reg, ext_mode_reg_1, ext_mode_reg_2, ext_mode_reg_3}, 0);
      chk({low_byte_strobe_complement_out, high_byte_strobe_complement_out,
           dq_oe, term_en}, 4'hC);
      $display("test reset done");
   endtask : t_reset

   task t_mode;
      for (int b = 0; b < 4; b++) cmd(dpc_pkg::CMD_LMR, 2'(b), 13'h0101 << b);
      wait_n(1);
      chk(base_mode_reg, 13'h0101);
      chk(ext_mode_reg_1, 13'h0202);
      chk(ext_mode_reg_2, 13'h0404);
      chk(ext_mode_reg_3, 13'h0808);
      $display("test mode done");
   endtask : t_mode

   task t_bank;
      cmd(4'hB, 2'h2, 13'h0000);
      wait_n(1);
      chk(bank_open, 4'h0);
      cmd(dpc_pkg::CMD_ACT, 2'h2, 13'h0000);
      cmd(dpc_pkg::CMD_ACT, 2'h0, 13'h0000);
      wait_n(1);
      chk(bank_open, 4'h5);
      cmd(dpc_pkg::CMD_PRE, 2'h2, 13'h0000);
      wait_n(1);
      chk(bank_open, 4'h1);
      cmd(dpc_pkg::CMD_ACT, 2'h3, 13'h0000);
      cmd(dpc_pkg::CMD_PRE, 2'h1, 13'h0400);
      wait_n(1);
      chk(bank_open, 4'h0);
      $display("test bank done");
   endtask : t_bank

   task t_write;
      logic [42:0] e;
      mdl.got.delete();
      cmd(dpc_pkg::CMD_ACT, 2'h3, 13'h0ABC);
      cmd(dpc_pkg::CMD_WR, 2'h3, 13'h0010);
      beat(1'b1, 1'b1, 1'b0, 1'b0, 16'h1111);
      beat(1'b1, 1'b1, 1'b1, 1'b0, 16'h2222);
      beat(1'b1, 1'b0, 1'b0, 1'b0, 16'h3333);
      beat(1'b1, 1'b1, 1'b0, 1'b1, 16'h4444);
      wait_n(4);
      chk(mdl.got.size(), 4);
      for (int i = 0; i < 4; i++) begin
         e = {2'h3, 13'h0ABC, 10'h010 + 10'(i), HI[i], LO[i],
              16'h1111 * 16'(i + 1)};
         chk(mdl.got[i], e);
      end
      $display("test write done");
   endtask : t_write

   task t_fifo;
      int n;
      stall <= 1'b1;
      mdl.got.delete();
      // Nine bursts give 36 beats, four more than the buffer can hold.
      for (int k = 0; k < 9; k++) begin
         cmd(dpc_pkg::CMD_WR, 2'h3, 13'h0000);
         repeat (4) beat(1'b1, 1'b1, 1'b0, 1'b0, 16'h5A5A);
      end
      wait_n(1);
      chk(wbuf_ready, 1'b0);
      chk(mdl.got.size(), 0);
      stall <= 1'b0;
      n = 0;
      while (mdl.got.size() < 32 && n < 100) begin
         wait_n(1);
         n++;
      end
      wait_n(4);
      chk(mdl.got.size(), 32);
      chk(wbuf_ready, 1'b1);
      $display("test buffer done");
   endtask : t_fifo

   task t_read(input logic coe);
      int n;
      cmd(dpc_pkg::CMD_ACT, 2'h1, 13'h0ABC);
      cmd(dpc_pkg::CMD_RD, 2'h1, 13'h0408);
      n = 0;
      wait_n(1);
      while (rd_req !== 1'b1 && n < 10) begin
         wait_n(1);
         n++;
      end
      chk(rd_bank, 2'h1);
      chk(rd_row, 13'h0ABC);
      for (int i = 0; i < 4; i++) begin
         chk(rd_col, 10'h008 + 10'(i));
         wait_n(1);
         chk(dq_out, {2'h1, 10'h008 + 10'(i), 4'hC});
         chk({dq_oe, strobe_oe, low_byte_strobe_out, high_byte_strobe_out},
             {2'b11, ~i[0], ~i[0]});
         chk({low_byte_strobe_complement_out, high_byte_strobe_complement_out},
             {i[0], i[0]});
         chk(strobe_complement_oe, coe);
      end
      wait_n(1);
      chk(dq_oe, 1'b0);
      chk(bank_open[1], 1'b0);
      cmd(dpc_pkg::CMD_PRE, 2'h0, 13'h0400);
      $display("test read done");
   endtask : t_read

   task t_power;
      @(posedge clk);
      cke <= 1'b0;
      wait_n(2);
      chk(pwr_state, 4'h2);
      cmd(dpc_pkg::CMD_ACT, 2'h0, 13'h0000);
      wait_n(1);
      chk(bank_open, 4'h0);
      @(posedge clk);
      cke <= 1'b1;
      wait_n(2);
      chk(pwr_state, 4'h1);
      cmd(dpc_pkg::CMD_ACT, 2'h0, 13'h0000);
      cke <= 1'b0;
      wait_n(2);
      chk(pwr_state, 4'h4);
      @(posedge clk);
      cke <= 1'b1;
      wait_n(2);
      chk(pwr_state, 4'h1);
      cmd(dpc_pkg::CMD_PRE, 2'h0, 13'h0400);
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= dpc_pkg::CMD_REF;
      cke <= 1'b0;
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= 4'hF;
      wait_n(2);
      chk(pwr_state, 4'h8);
      @(posedge clk);
      cke <= 1'b1;
      wait_n(2);
      chk(pwr_state, 4'h1);
      $display("test power done");
   endtask : t_power

   task t_term;
      @(posedge clk);
      termination_ctl <= 1'b1;
      wait_n(2);
      chk(term_en, 1'b0);
      cmd(dpc_pkg::CMD_LMR, 2'h1, 13'h0004);
      wait_n(2);
      chk(term_en, 1'b1);
      @(posedge clk);
      termination_ctl <= 1'b0;
      wait_n(2);
      chk(term_en, 1'b0);
      cmd(dpc_pkg::CMD_LMR, 2'h1, 13'h0400);
      $display("test termination done");
   endtask : t_term

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, cycles, 0);
         report_and_stop;
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      wait_n(1);
      t_reset;
      t_mode;
      t_bank;
      t_write;
      t_fifo;
      t_read(1'b1);
      t_power;
      t_term;
      t_read(1'b0);
      report_and_stop;
   end
endmodule : test_ddr2_pin_command_interface

// ---- hw/dpc_pkg.sv ----
// Constants, command codes and power states of the DRAM pin interface.
package dpc_pkg;
   localparam int DQ_W = 16;
   localparam int ROW_W = 13;
   localparam int COL_W = 10;
   localparam int BANK_W = 2;
   localparam int BANK_N = 4;
   localparam int AP_BIT = 10;
   localparam logic [2:0] BURST_LEN = 3'h4;
   localparam int WQ_DEPTH = 32;
   // Write entry: {bank, row, column, high drop, low drop, data}.
   localparam int WQ_LO_DROP = 16;
   localparam int WQ_HI_DROP = 17;
   localparam int WQ_W = BANK_W + ROW_W + COL_W + 2 + DQ_W;
   // Extended register 1 fields.
   localparam int DIFF_OFF_BIT = 10;
   localparam int TERM_BIT_A = 2;
   localparam int TERM_BIT_B = 6;
   localparam logic [1:0] MODE_EXT1 = 2'h1;
   localparam logic [ROW_W-1:0] MODE_RST = 13'h0000;
   // Command code {chip select, row, column, write}, all active low.
   localparam logic [3:0] CMD_LMR = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_RD = 4'h5;
   typedef enum logic [3:0] {
      PS_ON = 4'h1,
      PS_PPD = 4'h2,
      PS_APD = 4'h4,
      PS_SR = 4'h8
   } dpc_pwr_t;
endpackage : dpc_pkg

// ---- hw/dpc_top.sv ----
// Pin-side command decoder, bank state and data path of the DRAM device.
`timescale 1ns/1ns

// ----------------------------------------
// Write buffer
// ----------------------------------------
module dpc_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_ff;
   logic [AW-1:0] rp_ff;
   logic [AW:0] cnt_ff;
   logic push;
   logic pop;
   assign in_ready = cnt_ff != (AW+1)'(D);
   assign out_valid = cnt_ff != '0;
   assign out_data = mem[rp_ff];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_ff] <= in_data;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wp_ff <= (wp_ff == AW'(D-1)) ? '0 : wp_ff + 1'b1;
         end
         if (pop) begin
            rp_ff <= (rp_ff == AW'(D-1)) ? '0 : rp_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : dpc_fifo

// ----------------------------------------
// Device top
// ----------------------------------------
module dpc_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic bank_sel_0,
   input wire logic bank_sel_1,
   input wire logic [12:0] addr,
   input wire logic low_byte_mask,
   input wire logic high_byte_mask,
   input wire logic termination_ctl,
   input wire logic [15:0] dq_in,
   input wire logic low_byte_strobe_in,
   input wire logic low_byte_strobe_complement_in,
   input wire logic high_byte_strobe_in,
   input wire logic high_byte_strobe_complement_in,
   output logic [15:0] dq_out,
   output logic dq_oe,
   output logic low_byte_strobe_out,
   output logic low_byte_strobe_complement_out,
   output logic high_byte_strobe_out,
   output logic high_byte_strobe_complement_out,
   output logic strobe_oe,
   output logic strobe_complement_oe,
   output logic term_en,
   output logic [3:0] bank_open,
   output logic [3:0] pwr_state,
   output logic [12:0] base_mode_reg,
   output logic [12:0] ext_mode_reg_1,
   output logic [12:0] ext_mode_reg_2,
   output logic [12:0] ext_mode_reg_3,
   output logic rd_req,
   output logic [1:0] rd_bank,
   output logic [12:0] rd_row,
   output logic [9:0] rd_col,
   input wire logic [15:0] rd_data,
   output logic wq_valid,
   input wire logic wq_ready,
   output logic [42:0] wq_data,
   output logic wbuf_ready
);
   function automatic logic [3:0] bank_bit(input logic [1:0] b);
      bank_bit = 4'h1 << b;
   endfunction : bank_bit

   function automatic logic strobe_edge(input logic cur, input logic prev,
                                        input logic comp, input logic diff);
      strobe_edge = (cur != prev) && (!diff || (comp == !cur));
   endfunction : strobe_edge

   dpc_pkg::dpc_pwr_t pwr_st_ff;
   logic [3:0] open_ff;
   logic [12:0] row_ff [dpc_pkg::BANK_N];
   logic [12:0] mode_ff [dpc_pkg::BANK_N];
   logic ap_pend_ff;
   logic [1:0] ap_bank_ff;
   logic [2:0] left_ff;
   logic is_wr_ff;
   logic [1:0] bb_ff;
   logic [9:0] col_ff;
   logic ls_prev_ff;
   logic hs_prev_ff;
   logic rd_req_ff;
   logic [1:0] rd_bank_ff;
   logic [12:0] rd_row_ff;
   logic [9:0] rd_col_ff;
   logic [15:0] dq_out_ff;
   logic dq_oe_ff;
   logic ls_out_ff;
   logic hs_out_ff;
   logic comp_oe_ff;
   logic ls_comp_ff;
   logic hs_comp_ff;
   logic term_en_ff;
   logic wbuf_ready_ff;
   logic [3:0] cmd;
   logic [1:0] ba;
   logic cmd_ok;
   logic diff;
   logic term_allowed;
   logic rw_cmd;
   logic lo_edge;
   logic hi_edge;
   logic lo_drop;
   logic hi_drop;
   logic wr_beat;
   logic beat;
   logic ap_done;
   logic push;
   logic fifo_in_ready;
   logic [42:0] push_data;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   assign ba = {bank_sel_1, bank_sel_0};
   // Receivers are off outside the on state, so nothing decodes there.
   assign cmd_ok = (pwr_st_ff == dpc_pkg::PS_ON) && cke
                   && !cs_n;
   assign rw_cmd = cmd_ok && (cmd == dpc_pkg::CMD_RD
                              || cmd == dpc_pkg::CMD_WR);
   assign diff = !mode_ff[dpc_pkg::MODE_EXT1][dpc_pkg::DIFF_OFF_BIT];
   assign term_allowed = mode_ff[dpc_pkg::MODE_EXT1][dpc_pkg::TERM_BIT_A]
                      || mode_ff[dpc_pkg::MODE_EXT1][dpc_pkg::TERM_BIT_B];

   // ----------------------------------------
   // Power state
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_st_ff <= dpc_pkg::PS_ON;
      end else begin
         unique case (pwr_st_ff)
            dpc_pkg::PS_ON: begin
               if (!cke) begin
                  if (!cs_n && cmd == dpc_pkg::CMD_REF) begin
                     pwr_st_ff <= dpc_pkg::PS_SR;
                  end else if (|open_ff) begin
                     pwr_st_ff <= dpc_pkg::PS_APD;
                  end else begin
                     pwr_st_ff <= dpc_pkg::PS_PPD;
                  end
               end
            end
            dpc_pkg::PS_PPD, dpc_pkg::PS_APD: begin
               if (cke) begin
                  pwr_st_ff <= dpc_pkg::PS_ON;
               end
            end
            dpc_pkg::PS_SR: begin
               // Only clock enable is heard here; no command is needed.
               if (cke) begin
                  pwr_st_ff <= dpc_pkg::PS_ON;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Banks, rows and mode registers
   // ----------------------------------------
   assign ap_done = ap_pend_ff && left_ff == 3'h1 && beat;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         open_ff <= 4'h0;
         ap_pend_ff <= 1'b0;
         ap_bank_ff <= 2'h0;
         for (int i = 0; i < dpc_pkg::BANK_N; i++) begin
            row_ff[i] <= dpc_pkg::MODE_RST;
         end
      end else begin
         if (ap_done) begin
            open_ff[ap_bank_ff] <= 1'b0;
            ap_pend_ff <= 1'b0;
         end
         if (cmd_ok && cmd == dpc_pkg::CMD_ACT) begin
            open_ff[ba] <= 1'b1;
            row_ff[ba] <= addr;
         end
         if (cmd_ok && cmd == dpc_pkg::CMD_PRE) begin
            if (addr[dpc_pkg::AP_BIT]) begin
               open_ff <= 4'h0;
            end else begin
               open_ff[ba] <= 1'b0;
            end
         end
         if (rw_cmd) begin
            ap_pend_ff <= addr[dpc_pkg::AP_BIT];
            ap_bank_ff <= ba;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < dpc_pkg::BANK_N; i++) begin
            mode_ff[i] <= dpc_pkg::MODE_RST;
         end
      end else if (cmd_ok && cmd == dpc_pkg::CMD_LMR) begin
         mode_ff[ba] <= addr;
      end
   end

   // ----------------------------------------
   // Burst sequencing
   // ----------------------------------------
   assign beat = is_wr_ff ? wr_beat : 1'b1;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         left_ff <= 3'h0;
         is_wr_ff <= 1'b0;
         bb_ff <= 2'h0;
         col_ff <= 10'h000;
      end else if (rw_cmd) begin
         // A new burst cuts short the one in flight.
         left_ff <= dpc_pkg::BURST_LEN;
         is_wr_ff <= cmd == dpc_pkg::CMD_WR;
         bb_ff <= ba;
         col_ff <= addr[9:0];
      end else if (left_ff != 3'h0 && beat) begin
         left_ff <= left_ff - 3'h1;
         col_ff <= col_ff + 10'h001;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_req_ff <= 1'b0;
         rd_bank_ff <= 2'h0;
         rd_row_ff <= 13'h0000;
         rd_col_ff <= 10'h000;
      end else begin
         rd_req_ff <= left_ff != 3'h0 && !is_wr_ff;
         rd_bank_ff <= bb_ff;
         rd_row_ff <= row_ff[bb_ff];
         rd_col_ff <= col_ff;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dq_out_ff <= 16'h0000;
         dq_oe_ff <= 1'b0;
         ls_out_ff <= 1'b0;
         hs_out_ff <= 1'b0;
         ls_comp_ff <= 1'b1;
         hs_comp_ff <= 1'b1;
         comp_oe_ff <= 1'b0;
      end else if (rd_req_ff && pwr_st_ff == dpc_pkg::PS_ON) begin
         // Data and both lane strobes change on the same edge.
         dq_out_ff <= rd_data;
         dq_oe_ff <= 1'b1;
         ls_out_ff <= !ls_out_ff;
         hs_out_ff <= !hs_out_ff;
         // Complements get flops of their own so every pin leaves a register.
         ls_comp_ff <= ls_out_ff;
         hs_comp_ff <= hs_out_ff;
         comp_oe_ff <= diff;
      end else begin
         // No read request, or a power state other than on, disables the outputs.
         dq_oe_ff <= 1'b0;
         ls_out_ff <= 1'b0;
         hs_out_ff <= 1'b0;
         ls_comp_ff <= 1'b1;
         hs_comp_ff <= 1'b1;
         comp_oe_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // Write path
   // ----------------------------------------
   assign lo_edge = strobe_edge(low_byte_strobe_in, ls_prev_ff,
                                low_byte_strobe_complement_in, diff);
   assign hi_edge = strobe_edge(high_byte_strobe_in, hs_prev_ff,
                                high_byte_strobe_complement_in, diff);
   assign lo_drop = low_byte_mask || !lo_edge;
   assign hi_drop = high_byte_mask || !hi_edge;
   assign wr_beat = left_ff != 3'h0 && is_wr_ff && (lo_edge || hi_edge)
                    && pwr_st_ff == dpc_pkg::PS_ON && cke;
   // A beat with both lanes masked never reaches the buffer.
   assign push = wr_beat && !(lo_drop && hi_drop);
   assign push_data = {bb_ff, row_ff[bb_ff], col_ff, hi_drop, lo_drop, dq_in};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ls_prev_ff <= 1'b0;
         hs_prev_ff <= 1'b0;
         wbuf_ready_ff <= 1'b0;
      end else begin
         ls_prev_ff <= low_byte_strobe_in;
         hs_prev_ff <= high_byte_strobe_in;
         wbuf_ready_ff <= fifo_in_ready;
      end
   end

   // The controller cannot be stalled, so a beat met by a full buffer
   // is lost; wbuf_ready warns the user side to drain faster.
   dpc_fifo #(
      .W(dpc_pkg::WQ_W),
      .D(dpc_pkg::WQ_DEPTH)
   ) u_wbuf (
      .clk(clk),
      .rst(rst),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(wq_valid),
      .out_ready(wq_ready),
      .out_data(wq_data)
   );

   // ----------------------------------------
   // Termination
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         term_en_ff <= 1'b0;
      end else begin
         term_en_ff <= termination_ctl && term_allowed
                       && pwr_st_ff != dpc_pkg::PS_SR;
      end
   end

   assign dq_out = dq_out_ff;
   assign dq_oe = dq_oe_ff;
   assign low_byte_strobe_out = ls_out_ff;
   assign high_byte_strobe_out = hs_out_ff;
   assign low_byte_strobe_complement_out = ls_comp_ff;
   assign high_byte_strobe_complement_out = hs_comp_ff;
   assign strobe_oe = dq_oe_ff;
   assign strobe_complement_oe = comp_oe_ff;
   assign term_en = term_en_ff;
   assign bank_open = open_ff;
   assign pwr_state = pwr_st_ff;
   assign base_mode_reg = mode_ff[0];
   assign ext_mode_reg_1 = mode_ff[1];
   assign ext_mode_reg_2 = mode_ff[2];
   assign ext_mode_reg_3 = mode_ff[3];
   assign rd_req = rd_req_ff;
   assign rd_bank = rd_bank_ff;
   assign rd_row = rd_row_ff;
   assign rd_col = rd_col_ff;
   assign wbuf_ready = wbuf_ready_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_rd_cmd;
      cmd_ok && cmd == dpc_pkg::CMD_RD;
   endsequence
   sequence s_rd_first;
      rd_req_ff && rd_col_ff == $past(addr[9:0], 2)
      && rd_bank_ff == $past(ba, 2);
   endsequence
   property p_rd_start;
      @(posedge clk) disable iff (rst) s_rd_cmd |-> ##2 s_rd_first;
   endproperty
   a_rd_start: assert property (p_rd_start)
      else $error("read burst did not start at the sampled column");
   property p_rd_out;
      @(posedge clk) disable iff (rst)
      (rd_req_ff && pwr_st_ff == dpc_pkg::PS_ON) |=> dq_oe_ff
      && dq_out_ff == $past(rd_data) && ls_out_ff != $past(ls_out_ff);
   endproperty
   a_rd_out: assert property (p_rd_out)
      else $error("read beat not driven with a strobe edge");
   property p_cs_mask;
      @(posedge clk) disable iff (rst)
      (cs_n && !ap_done) |=> open_ff == $past(open_ff);
   endproperty
   a_cs_mask: assert property (p_cs_mask)
      else $error("bank state changed while deselected");
   property p_pre_all;
      @(posedge clk) disable iff (rst)
      (cmd_ok && cmd == dpc_pkg::CMD_PRE && addr[dpc_pkg::AP_BIT])
      |=> open_ff == 4'h0;
   endproperty
   a_pre_all: assert property (p_pre_all)
      else $error("precharge all left a bank open");
   property p_pre_one;
      @(posedge clk) disable iff (rst)
      (cmd_ok && cmd == dpc_pkg::CMD_PRE && !addr[dpc_pkg::AP_BIT] && !ap_done)
      |=> open_ff == ($past(open_ff) & ~bank_bit($past(ba)));
   endproperty
   a_pre_one: assert property (p_pre_one)
      else $error("single-bank precharge touched another bank");
   property p_act;
      @(posedge clk) disable iff (rst) (cmd_ok && cmd == dpc_pkg::CMD_ACT)
      |=> open_ff[$past(ba)] && row_ff[$past(ba)] == $past(addr);
   endproperty
   a_act: assert property (p_act)
      else $error("activate did not open the row");
   property p_lmr;
      @(posedge clk) disable iff (rst) (cmd_ok && cmd == dpc_pkg::CMD_LMR)
      |=> mode_ff[$past(ba)] == $past(addr);
   endproperty
   a_lmr: assert property (p_lmr)
      else $error("mode register not loaded");
   property p_apd;
      @(posedge clk) disable iff (rst)
      (pwr_st_ff == dpc_pkg::PS_ON && !cke && |open_ff
       && !(!cs_n && cmd == dpc_pkg::CMD_REF))
      |=> pwr_st_ff == dpc_pkg::PS_APD;
   endproperty
   a_apd: assert property (p_apd)
      else $error("active power-down not entered");
   property p_sr_exit;
      @(posedge clk) disable iff (rst)
      (pwr_st_ff == dpc_pkg::PS_SR && cke) |=> pwr_st_ff == dpc_pkg::PS_ON;
   endproperty
   a_sr_exit: assert property (p_sr_exit)
      else $error("self refresh not left on clock enable");
   property p_term;
      @(posedge clk) disable iff (rst)
      (!term_allowed || pwr_st_ff == dpc_pkg::PS_SR) |=> !term_en_ff;
   endproperty
   a_term: assert property (p_term)
      else $error("termination on while disabled");
   property p_mask;
      @(posedge clk) disable iff (rst)
      (wr_beat && low_byte_mask && high_byte_mask && !(wq_valid && wq_ready))
      |=> u_wbuf.cnt_ff == $past(u_wbuf.cnt_ff);
   endproperty
   a_mask: assert property (p_mask)
      else $error("fully masked beat entered the buffer");
endmodule : dpc_top
